// ### design/exception_sequencer.sv
// Purpose : recognises, orders and takes exceptions; saves context, redirects fetch
// Assumes : older_busy is high while any older instruction has not completed;
//           completion logic holds back while completion_stall is high
// Notes   : registers on a plain port, read data one cycle after the read strobe
//
// The plain strobed port and the address map were left to the implementer.

module exception_sequencer (
   input  wire logic                           clk,
   input  wire logic                           nrst,
   input  wire logic [exc_pkg::RADDR_W-1:0]    reg_addr,
   input  wire logic [exc_pkg::DATA_W-1:0]     reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic      [exc_pkg::DATA_W-1:0]     reg_rdata,
   input  wire logic                           cmpl_valid,
   input  wire logic [exc_pkg::DATA_W-1:0]     cmpl_addr,
   input  wire logic [exc_pkg::SYNC_W-1:0]     cmpl_exc,
   input  wire logic [exc_pkg::DATA_W-1:0]     cmpl_cause,
   input  wire logic                           older_busy,
   input  wire logic [exc_pkg::DATA_W-1:0]     next_addr,
   input  wire logic                           state_corrupt,
   input  wire logic                           hard_reset_req,
   input  wire logic                           soft_reset_req,
   input  wire logic                           machine_check_input,
   input  wire logic                           bus_parity_err,
   input  wire logic                           ext_int_req,
   input  wire logic                           sysmgmt_int_req,
   input  wire logic                           decr_int_req,
   input  wire logic                           perf_int_req,
   output logic                                fetch_redirect,
   output logic      [exc_pkg::VEC_W-1:0]      fetch_vector,
   output logic                                supervisor_mode,
   output logic                                completion_stall,
   output logic                                checkstop
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [exc_pkg::PIN_W-1:0] pin_meta_reg;
   logic [exc_pkg::PIN_W-1:0] pin_sync_reg;
   logic [exc_pkg::PIN_W-1:0] pin_prev_reg;
   logic [exc_pkg::PIN_W-1:0] pin_raw;

   assign pin_raw = {sysmgmt_int_req, ext_int_req, bus_parity_err,
                     machine_check_input, soft_reset_req, hard_reset_req};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
         pin_prev_reg <= '0;
      end else begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   logic reset_edge;
   logic mchk_edge;
   logic par_s;
   logic ext_s;
   logic smi_s;

   // reset pins are edge requests so a held pin does not retrigger
   assign reset_edge = (pin_sync_reg[exc_pkg::PIN_HRST] & ~pin_prev_reg[exc_pkg::PIN_HRST]) |
                       (pin_sync_reg[exc_pkg::PIN_SRST] & ~pin_prev_reg[exc_pkg::PIN_SRST]);
   assign mchk_edge  = pin_sync_reg[exc_pkg::PIN_MCHK] & ~pin_prev_reg[exc_pkg::PIN_MCHK];
   assign par_s      = pin_sync_reg[exc_pkg::PIN_PAR];
   assign ext_s      = pin_sync_reg[exc_pkg::PIN_EXT];
   assign smi_s      = pin_sync_reg[exc_pkg::PIN_SMI];

   // ------------------------------------------------------------
   // sequencer state
   // ------------------------------------------------------------
   exc_pkg::seq_state_type      state_reg, state_next;
   logic [exc_pkg::DATA_W-1:0]  msr_reg, msr_next;
   logic [exc_pkg::DATA_W-1:0]  save_addr_reg, save_addr_next;
   logic [exc_pkg::DATA_W-1:0]  save_state_reg, save_state_next;
   logic [exc_pkg::DATA_W-1:0]  fault_reg, fault_next;
   logic [exc_pkg::DATA_W-1:0]  data_fault_cause_reg, data_fault_next;
   logic [exc_pkg::SRC_W-1:0]   cause_reg, cause_next;
   logic [exc_pkg::SYNC_W-1:0]  sync_left_reg, sync_left_next;
   logic                        sync_go_reg, sync_go_next;
   logic [exc_pkg::DATA_W-1:0]  sync_addr_reg, sync_addr_next;
   logic                        reset_pend_reg, reset_pend_next;
   logic                        mchk_pend_reg, mchk_pend_next;
   logic                        redirect_reg, redirect_next;
   logic [exc_pkg::VEC_W-1:0]   vector_reg, vector_next;
   logic                        super_reg, super_next;
   logic                        stall_reg, stall_next;
   logic                        stop_reg, stop_next;
   logic [exc_pkg::DATA_W-1:0]  rdata_reg, rdata_next;

   logic [exc_pkg::NUM_SRC-1:0] req;
   logic [exc_pkg::SRC_W-1:0]   pick_idx;
   logic                        pick_any;
   logic                        take;
   logic                        take_sync;
   logic                        stop_cond;
   logic                        return_evt;

   // synchronous sources come from completion, the rest from pins and timers
   always_comb begin
      req = '0;
      req[exc_pkg::SRC_RESET] = reset_pend_reg;
      req[exc_pkg::SRC_MCHK]  = mchk_pend_reg;
      req[exc_pkg::SYNC_LO +: exc_pkg::SYNC_W] = sync_go_reg ? sync_left_reg : '0;
      req[exc_pkg::SRC_EXT]   = ext_s & msr_reg[exc_pkg::BIT_EE];
      req[exc_pkg::SRC_DECR]  = decr_int_req & msr_reg[exc_pkg::BIT_EE];
      req[exc_pkg::SRC_SMI]   = smi_s & msr_reg[exc_pkg::BIT_SME];
      req[exc_pkg::SRC_PERF]  = perf_int_req & msr_reg[exc_pkg::BIT_PME];
   end

   exc_priority_pick #(
      .N  (exc_pkg::NUM_SRC),
      .IW (exc_pkg::SRC_W)
   ) u_pick (
      .req   (req),
      .index (pick_idx),
      .any   (pick_any)
   );

   assign stop_cond  = par_s | (mchk_edge & ~msr_reg[exc_pkg::BIT_ME]);
   assign return_evt = reg_wr & (reg_addr == exc_pkg::OFS_RETURN);
   assign take_sync  = (pick_idx >= exc_pkg::SRC_DSTOR) & (pick_idx <= exc_pkg::SRC_FLOAT);

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      state_next      = state_reg;
      msr_next        = msr_reg;
      save_addr_next  = save_addr_reg;
      save_state_next = save_state_reg;
      fault_next      = fault_reg;
      data_fault_next = data_fault_cause_reg;
      cause_next      = cause_reg;
      sync_left_next  = sync_left_reg;
      sync_go_next    = sync_go_reg;
      sync_addr_next  = sync_addr_reg;
      reset_pend_next = reset_pend_reg;
      mchk_pend_next  = mchk_pend_reg;
      vector_next     = vector_reg;
      redirect_next   = 1'b0;
      rdata_next      = '0;
      take            = 1'b0;

      if (reg_wr) begin
         case (reg_addr)
            exc_pkg::OFS_MACHINE_STATE: msr_next        = reg_wdata;
            exc_pkg::OFS_SAVE_ADDR:     save_addr_next  = reg_wdata;
            exc_pkg::OFS_SAVE_STATE:    save_state_next = reg_wdata;
            exc_pkg::OFS_DATA_FAULT:    data_fault_next = reg_wdata;
            exc_pkg::OFS_RETURN:        msr_next        = save_state_reg;
            default: ;
         endcase
      end

      case (state_reg)
         exc_pkg::ST_RUN: begin
            if (cmpl_valid && (|cmpl_exc)) begin
               // hold younger completions until this instruction's fault is taken
               sync_left_next = cmpl_exc;
               sync_go_next   = 1'b1;
               sync_addr_next = cmpl_addr;
               fault_next     = cmpl_cause;
               state_next     = exc_pkg::ST_DRAIN;
            end else if (return_evt && (|sync_left_reg)) begin
               sync_go_next = 1'b1;
               state_next   = exc_pkg::ST_DRAIN;
            end else if (pick_any) begin
               state_next = exc_pkg::ST_DRAIN;
            end
         end
         exc_pkg::ST_DRAIN: begin
            if (!older_busy) begin
               if (pick_any) begin
                  take = 1'b1;
               end
               state_next = exc_pkg::ST_RUN;
            end
         end
         exc_pkg::ST_STOP: state_next = exc_pkg::ST_STOP;
         default:          state_next = exc_pkg::ST_RUN;
      endcase

      if (stop_cond || state_reg == exc_pkg::ST_STOP) begin
         take       = 1'b0;
         state_next = exc_pkg::ST_STOP;
      end

      if (take) begin
         // a take overrides a software write of the same cycle to machine state and both save registers
         save_addr_next  = take_sync ? sync_addr_reg : next_addr;
         save_state_next = msr_reg;
         if (state_corrupt && pick_idx <= exc_pkg::SRC_MCHK) begin
            save_state_next[exc_pkg::BIT_RI] = 1'b0;
         end
         msr_next                       = msr_reg;
         msr_next[exc_pkg::BIT_PROBLEM] = 1'b0;
         msr_next[exc_pkg::BIT_EE]      = 1'b0;
         msr_next[exc_pkg::BIT_ME]      = 1'b0;
         cause_next    = pick_idx;
         vector_next   = exc_pkg::vector_of(pick_idx);
         redirect_next = 1'b1;
         if (pick_idx == exc_pkg::SRC_DSTOR) begin
            data_fault_next = fault_reg;
         end
         for (int i = 0; i < exc_pkg::SYNC_W; i++) begin
            if (pick_idx == exc_pkg::SRC_W'(exc_pkg::SYNC_LO + i)) begin
               sync_left_next[i] = 1'b0;
            end
         end
         if (take_sync) begin
            sync_go_next = 1'b0;
         end
         if (pick_idx == exc_pkg::SRC_RESET) begin
            reset_pend_next = 1'b0;
         end
         if (pick_idx == exc_pkg::SRC_MCHK) begin
            mchk_pend_next = 1'b0;
         end
      end

      // new events win over the clear of a take in the same cycle
      if (reset_edge) begin
         reset_pend_next = 1'b1;
      end
      if (mchk_edge && msr_reg[exc_pkg::BIT_ME]) begin
         mchk_pend_next = 1'b1;
      end

      if (reg_rd) begin
         case (reg_addr)
            exc_pkg::OFS_MACHINE_STATE: rdata_next = msr_reg;
            exc_pkg::OFS_SAVE_ADDR:     rdata_next = save_addr_reg;
            exc_pkg::OFS_SAVE_STATE:    rdata_next = save_state_reg;
            exc_pkg::OFS_DATA_FAULT:    rdata_next = data_fault_cause_reg;
            exc_pkg::OFS_CAUSE:         rdata_next = exc_pkg::DATA_W'(cause_reg);
            exc_pkg::OFS_STATUS:        rdata_next = exc_pkg::DATA_W'({mchk_pend_reg,
                                           reset_pend_reg, sync_go_reg, sync_left_reg,
                                           state_reg});
            default:                    rdata_next = '0;
         endcase
      end

      super_next = ~msr_next[exc_pkg::BIT_PROBLEM];
      stall_next = (state_next != exc_pkg::ST_RUN);
      stop_next  = (state_next == exc_pkg::ST_STOP);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg            <= exc_pkg::ST_RUN;
         msr_reg              <= exc_pkg::MACHINE_STATE_RESET;
         save_addr_reg        <= '0;
         save_state_reg       <= '0;
         fault_reg            <= '0;
         data_fault_cause_reg <= '0;
         cause_reg            <= '0;
         sync_left_reg        <= '0;
         sync_go_reg          <= 1'b0;
         sync_addr_reg        <= '0;
         reset_pend_reg       <= 1'b0;
         mchk_pend_reg        <= 1'b0;
         redirect_reg         <= 1'b0;
         vector_reg           <= '0;
         super_reg            <= 1'b1;
         stall_reg            <= 1'b0;
         stop_reg             <= 1'b0;
         rdata_reg            <= '0;
      end else begin
         state_reg            <= state_next;
         msr_reg              <= msr_next;
         save_addr_reg        <= save_addr_next;
         save_state_reg       <= save_state_next;
         fault_reg            <= fault_next;
         data_fault_cause_reg <= data_fault_next;
         cause_reg            <= cause_next;
         sync_left_reg        <= sync_left_next;
         sync_go_reg          <= sync_go_next;
         sync_addr_reg        <= sync_addr_next;
         reset_pend_reg       <= reset_pend_next;
         mchk_pend_reg        <= mchk_pend_next;
         redirect_reg         <= redirect_next;
         vector_reg           <= vector_next;
         super_reg            <= super_next;
         stall_reg            <= stall_next;
         stop_reg             <= stop_next;
         rdata_reg            <= rdata_next;
      end
   end

   assign reg_rdata        = rdata_reg;
   assign fetch_redirect   = redirect_reg;
   assign fetch_vector     = vector_reg;
   assign supervisor_mode  = super_reg;
   assign completion_stall = stall_reg;
   assign checkstop        = stop_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_take;
      fetch_redirect;
   endsequence
   sequence s_sync_fault;
      state_reg == exc_pkg::ST_RUN && cmpl_valid && (|cmpl_exc) && !stop_cond;
   endsequence
   AST_TAKE_PRIV: assert property (s_take |-> supervisor_mode && !msr_reg[exc_pkg::BIT_PROBLEM]
      && !msr_reg[exc_pkg::BIT_EE])
      else $error("take without supervisor state");
   AST_TAKE_VECTOR: assert property (s_take
      |-> fetch_vector == exc_pkg::vector_of(cause_reg))
      else $error("vector does not match cause");
   AST_RESET_VEC: assert property (s_take and cause_reg == exc_pkg::SRC_RESET
      |-> fetch_vector == 20'h0_0100)
      else $error("system reset at wrong vector");
   AST_MCHK_VEC: assert property (s_take and cause_reg == exc_pkg::SRC_MCHK
      |-> fetch_vector == 20'h0_0200 && !checkstop)
      else $error("machine check at wrong vector");
   AST_DRAINED: assert property (s_take |-> $past(!older_busy))
      else $error("take before older instructions drained");
   AST_HOLD: assert property (s_sync_fault |=> completion_stall)
      else $error("completion not held after fault");
   AST_PARITY_STOP: assert property (par_s |=> checkstop ##1 checkstop)
      else $error("parity error did not checkstop");
   AST_MASKED_EXT: assert property (s_take and cause_reg == exc_pkg::SRC_EXT
      |-> $past(msr_reg[exc_pkg::BIT_EE]))
      else $error("external taken while masked");
   AST_PRIO: assert property (s_take and cause_reg == exc_pkg::SRC_DECR
      |-> !$past(req[exc_pkg::SRC_EXT]))
      else $error("lower priority taken first");
   AST_ONE_COND: assert property (s_take and $past(take_sync)
      |-> $countones(sync_left_reg) + 1 == $countones($past(sync_left_reg)))
      else $error("conditions of one instruction merged");
   AST_RI_CLEAR: assert property (s_take and $past(state_corrupt)
      && cause_reg == exc_pkg::SRC_RESET |-> !save_state_reg[exc_pkg::BIT_RI])
      else $error("recoverable flag kept on corrupt take");
   AST_DFAULT: assert property (s_take and cause_reg == exc_pkg::SRC_DSTOR
      |-> data_fault_cause_reg == fault_reg)
      else $error("data fault cause not recorded");

endmodule

// ### design/exc_pkg.sv
// Purpose : shared constants, vector table and state type of the exception sequencer
// Assumes : one core clock, asynchronous active-low reset
// Notes   : source indices double as priority order, lowest index wins
package exc_pkg;

   localparam int DATA_W  = 32;
   localparam int RADDR_W = 4;
   localparam int VEC_W   = 20;
   localparam int NUM_SRC = 10;
   localparam int SRC_W   = 4;
   localparam int SYNC_W  = 4;
   localparam int SYNC_LO = 2;
   localparam int PIN_W   = 6;

   // ------------------------------------------------------------
   // register offsets (word index on the register port)
   // ------------------------------------------------------------
   localparam logic [RADDR_W-1:0] OFS_MACHINE_STATE = 4'h0;
   localparam logic [RADDR_W-1:0] OFS_SAVE_ADDR     = 4'h1;
   localparam logic [RADDR_W-1:0] OFS_SAVE_STATE    = 4'h2;
   localparam logic [RADDR_W-1:0] OFS_DATA_FAULT    = 4'h3;
   localparam logic [RADDR_W-1:0] OFS_CAUSE         = 4'h4;
   localparam logic [RADDR_W-1:0] OFS_RETURN        = 4'h5;
   localparam logic [RADDR_W-1:0] OFS_STATUS        = 4'h6;

   // ------------------------------------------------------------
   // machine state fields and reset values
   // ------------------------------------------------------------
   localparam int BIT_RI      = 0;
   localparam int BIT_PROBLEM = 1;
   localparam int BIT_ME      = 2;
   localparam int BIT_EE      = 3;
   localparam int BIT_PME     = 4;
   localparam int BIT_SME     = 5;
   localparam logic [DATA_W-1:0] MACHINE_STATE_RESET = 32'h0000_0000;

   // ------------------------------------------------------------
   // sources in priority order
   // ------------------------------------------------------------
   localparam logic [SRC_W-1:0] SRC_RESET = 4'h0;
   localparam logic [SRC_W-1:0] SRC_MCHK  = 4'h1;
   localparam logic [SRC_W-1:0] SRC_DSTOR = 4'h2;
   localparam logic [SRC_W-1:0] SRC_ISTOR = 4'h3;
   localparam logic [SRC_W-1:0] SRC_PROG  = 4'h4;
   localparam logic [SRC_W-1:0] SRC_FLOAT = 4'h5;
   localparam logic [SRC_W-1:0] SRC_EXT   = 4'h6;
   localparam logic [SRC_W-1:0] SRC_DECR  = 4'h7;
   localparam logic [SRC_W-1:0] SRC_SMI   = 4'h8;
   localparam logic [SRC_W-1:0] SRC_PERF  = 4'h9;

   // synchronised pin positions
   localparam int PIN_HRST = 0;
   localparam int PIN_SRST = 1;
   localparam int PIN_MCHK = 2;
   localparam int PIN_PAR  = 3;
   localparam int PIN_EXT  = 4;
   localparam int PIN_SMI  = 5;

   // ------------------------------------------------------------
   // vector offsets
   // ------------------------------------------------------------
   localparam logic [VEC_W-1:0] VEC_RESET = 20'h0_0100;
   localparam logic [VEC_W-1:0] VEC_MCHK  = 20'h0_0200;
   localparam logic [VEC_W-1:0] VEC_DSTOR = 20'h0_0300;
   localparam logic [VEC_W-1:0] VEC_ISTOR = 20'h0_0400;
   localparam logic [VEC_W-1:0] VEC_EXT   = 20'h0_0500;
   localparam logic [VEC_W-1:0] VEC_PROG  = 20'h0_0700;
   localparam logic [VEC_W-1:0] VEC_FLOAT = 20'h0_0800;
   localparam logic [VEC_W-1:0] VEC_DECR  = 20'h0_0900;
   localparam logic [VEC_W-1:0] VEC_PERF  = 20'h0_0F00;
   localparam logic [VEC_W-1:0] VEC_SMI   = 20'h0_1400;

   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_DRAIN = 3'b010,
      ST_STOP  = 3'b100
   } seq_state_type;

   function automatic logic [VEC_W-1:0] vector_of(input logic [SRC_W-1:0] src);
      case (src)
         SRC_RESET: vector_of = VEC_RESET;
         SRC_MCHK:  vector_of = VEC_MCHK;
         SRC_DSTOR: vector_of = VEC_DSTOR;
         SRC_ISTOR: vector_of = VEC_ISTOR;
         SRC_PROG:  vector_of = VEC_PROG;
         SRC_FLOAT: vector_of = VEC_FLOAT;
         SRC_EXT:   vector_of = VEC_EXT;
         SRC_DECR:  vector_of = VEC_DECR;
         SRC_SMI:   vector_of = VEC_SMI;
         SRC_PERF:  vector_of = VEC_PERF;
         default:   vector_of = VEC_RESET;
      endcase
   endfunction

endpackage

// ### design/exc_priority_pick.sv
// Purpose : fixed-priority pick of one request, lowest index first
// Assumes : purely combinational, same clock domain as the caller
// Notes   : index is zero when nothing is requested; check any first
module exc_priority_pick #(
   parameter int N  = 10,
   parameter int IW = 4
) (
   input  wire logic [N-1:0]  req,
   output logic      [IW-1:0] index,
   output logic               any
);

   function automatic logic [IW-1:0] lowest_set(input logic [N-1:0] v);
      logic [IW-1:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = IW'(i);
         end
      end
      return r;
   endfunction

   always_comb begin
      index = lowest_set(req);
      any   = |req;
   end

endmodule

// ### tb/exc_partner_model.sv
// Purpose : completion logic model reporting the oldest instruction
// Assumes : one issue pulse per instruction, driven by the bench
// Notes   : a report offered during a stall is dropped, not queued
module exc_partner_model (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       issue,
   input  wire logic [3:0] issue_exc,
   input  wire logic       busy_on,
   input  wire logic       completion_stall,
   output logic            cmpl_valid,
   output logic      [3:0] cmpl_exc,
   output logic            older_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cmpl_valid <= 1'b0;
         cmpl_exc   <= 4'h0;
         older_busy <= 1'b0;
      end else begin
         cmpl_valid <= issue && !completion_stall;
         // conditions are meaningless outside a report, so show the inverse there
         cmpl_exc   <= (issue && !completion_stall) ? issue_exc : ~issue_exc;
         older_busy <= busy_on;
      end
   end
endmodule

// ### tb/test_exception_sequencer.sv
// Purpose : self-checking bench of the exception sequencer
// Assumes : 20 MHz clock, inputs driven after rising edges
// Notes   : expected vectors queue up and are matched at each redirect
module test_exception_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, nrst = 0, wr = 0, rd = 0, issue = 0, busy = 0, par = 0;
   logic [2:0]  pin = 3'h0;
   logic        corrupt = 0, decr = 0;
   logic [3:0]  addr = 4'h0, iexc = 4'h0, cexc;
   logic [31:0] wd = 32'h0, caddr = 32'h0, seed = 32'hea4c_2cab, rdat;
   logic        cv, ob, redir, sup, stall, cstop;
   logic [19:0] vec, exp_q[$];
   int          bad_count = 0, samples_checked = 0, takes = 0, t0;
   localparam logic [19:0] VT [3] = '{exc_pkg::VEC_RESET, exc_pkg::VEC_MCHK, exc_pkg::VEC_EXT};
   // machine state written before each pin take: recoverable, check enable, external enable
   localparam logic [31:0] MW [3] = '{32'h0000_0001, 32'h0000_0005, 32'h0000_0008};
   always #25 clk = ~clk;
   exc_partner_model i_exc_partner_model (.clk(clk), .nrst(nrst), .issue(issue),
      .issue_exc(iexc), .busy_on(busy), .completion_stall(stall), .cmpl_valid(cv),
      .cmpl_exc(cexc), .older_busy(ob));
   exception_sequencer i_exception_sequencer (.clk(clk), .nrst(nrst), .reg_addr(addr),
      .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .cmpl_valid(cv),
      .cmpl_addr(caddr), .cmpl_exc(cexc), .cmpl_cause(seed), .older_busy(ob),
      .next_addr(~caddr), .state_corrupt(corrupt), .hard_reset_req(pin[0]),
      .soft_reset_req(1'b0), .machine_check_input(pin[1]), .bus_parity_err(par),
      .ext_int_req(pin[2]), .sysmgmt_int_req(1'b0), .decr_int_req(decr),
      .perf_int_req(1'b0), .fetch_redirect(redir), .fetch_vector(vec),
      .supervisor_mode(sup), .completion_stall(stall), .checkstop(cstop));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task complete_run();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task bw(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk) addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk) wr <= 1'b0;
   endtask
   task br(input logic [3:0] a, input logic [31:0] e, input string n);
      @(posedge clk) addr <= a;
      rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      @(negedge clk) chk(n, e, rdat);
   endtask
   task sync(input logic [3:0] e);
      @(posedge clk) caddr <= seed;
      seed <= lfsr(seed);
      iexc <= e;
      issue <= 1'b1;
      @(posedge clk) issue <= 1'b0;
   endtask
   task expect_take(input logic [19:0] v);
      t0 = takes;
      exp_q.push_back(v);
      repeat (30) if (takes == t0) @(negedge clk);
      chk("take count", t0 + 1, takes);
   endtask
   task idle_check(input int n);
      t0 = takes;
      repeat (n) @(posedge clk);
      chk("no take", t0, takes);
   endtask
   always @(negedge clk) if (redir === 1'b1) begin
      takes++;
      chk("vector", exp_q.size() ? 32'(exp_q.pop_front()) : 32'hffff_ffff, 32'(vec));
      chk("supervisor", 1, sup);
   end
   initial begin
      #100000;
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk) chk("supervisor", 1, sup);
      br(exc_pkg::OFS_MACHINE_STATE, exc_pkg::MACHINE_STATE_RESET, "state");
      br(4'hf, 0, "unmapped");
      sync(4'h5);
      expect_take(exc_pkg::VEC_DSTOR);
      br(exc_pkg::OFS_CAUSE, 32'(exc_pkg::SRC_DSTOR), "cause");
      br(exc_pkg::OFS_SAVE_ADDR, caddr, "save address");
      bw(exc_pkg::OFS_RETURN, 0);
      expect_take(exc_pkg::VEC_PROG);
      @(posedge clk) busy <= 1'b1;
      sync(4'h2);
      idle_check(10);
      @(posedge clk) busy <= 1'b0;
      expect_take(exc_pkg::VEC_ISTOR);
      for (int i = 0; i < 3; i++) begin
         if (i < 2) bw(exc_pkg::OFS_MACHINE_STATE, MW[i]);
         @(posedge clk) pin[i] <= 1'b1;
         corrupt <= (i == 0);
         if (i == 2) idle_check(10);
         if (i == 2) bw(exc_pkg::OFS_MACHINE_STATE, MW[i]);
         expect_take(VT[i]);
         @(posedge clk) pin[i] <= 1'b0;
         br(exc_pkg::OFS_SAVE_STATE, MW[i] & ~32'(i == 0), "save state");
      end
      // external and decrementer both pending: external first, decrementer deferred
      @(posedge clk) pin[2] <= 1'b1;
      decr <= 1'b1;
      bw(exc_pkg::OFS_MACHINE_STATE, MW[2]);
      expect_take(exc_pkg::VEC_EXT);
      @(posedge clk) pin[2] <= 1'b0;
      bw(exc_pkg::OFS_MACHINE_STATE, MW[2]);
      expect_take(exc_pkg::VEC_DECR);
      @(posedge clk) decr <= 1'b0;
      @(posedge clk) par <= 1'b1;
      repeat (6) @(posedge clk);
      chk("checkstop", 1, cstop);
      chk("stall", 1, stall);
      sync(4'h1);
      idle_check(10);
      // checkstop is left only through the reset input
      @(posedge clk) nrst <= 1'b0;
      par <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk) chk("checkstop", 0, cstop);
      sync(4'h1);
      expect_take(exc_pkg::VEC_DSTOR);
      complete_run();
   end
endmodule
